//--- core/rsi_flag_unit.sv
// reset-cause flag logic for the status flags
`timescale 1ns/1ps
module rsi_flag_unit
  import rsi_pkg::*;
(
  // clock and control
  input wire logic clk_sys,
  input wire logic ce,
  // reset kind, one-cycle pulses except ev_por while rst_n is held, at most one at a time
  input wire logic ev_por,
  input wire logic ev_wdt,
  input wire logic in_sleep,
  // flags out
  output rsi_flags_s flags
);
  // por clears both, pin/lvr leave them, wdt sets per mode
  always_ff @(posedge clk_sys) begin
    if (ce) begin
      if (ev_por) begin
        flags <= '0;
      end else if (ev_wdt) begin
        flags.watchdog_timeout_flag <= 1'b1;
        if (in_sleep) begin
          flags.powerdown_flag <= 1'b1;
        end
      end
    end
  end
endmodule

//--- core/rsi_pkg.sv
// shared constants, types and register map of the reset-state initialiser
package rsi_pkg;
  // apb register byte offsets
  localparam logic [7:0] REG_CAUSE = 8'h00;
  localparam logic [7:0] REG_CTRL = 8'h04;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0c;
  localparam logic [7:0] REG_STATE = 8'h10;
  localparam logic [7:0] REG_COUNT = 8'h14;
  // cause register fields
  localparam int CAUSE_TO_BIT = 0;
  localparam int CAUSE_PD_BIT = 1;
  // ctrl register fields
  localparam int CTRL_SLEEP_BIT = 0;
  localparam int CTRL_RUN_BIT = 1;
  localparam int CTRL_IRQEN_BIT = 2;
  localparam int CTRL_TIMER_BIT = 3;
  // irq status bit positions, one per reset kind
  localparam int EV_POR = 0;
  localparam int EV_PIN = 1;
  localparam int EV_LVR = 2;
  localparam int EV_WDT = 3;
  localparam int EV_WDT_SLEEP = 4;
  localparam int EV_N = 5;
  // reset values
  localparam logic [7:0] PC_RESET = 8'h00;
  localparam logic [7:0] PORT_DIR_RESET = 8'hff;
  localparam logic [7:0] PRESCALE_RESET = 8'h00;
  localparam logic [3:0] SP_TOP = 4'hf;
  localparam logic [15:0] WDT_RESET = 16'h0000;
  // init sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_APPLY = 3'b010,
    ST_RELEASE = 3'b100
  } rsi_state_e;
  // reset-cause flags carried together
  typedef struct packed {
    logic powerdown_flag;
    logic watchdog_timeout_flag;
  } rsi_flags_s;
  // apb request bundle
  typedef struct packed {
    logic sel;
    logic en;
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
  } rsi_apb_req_s;
endpackage

//--- core/rsi_top.sv
// reset-state initialiser: cause flags, reset-state loading, apb registers
// What this block does
// - a power-on reset clears the watchdog timeout flag and the powerdown flag.
// - a pin or low-voltage reset leaves both flags unchanged.
// - a watchdog timeout in normal operation sets the timeout flag and keeps the powerdown flag.
// - a watchdog timeout in sleep sets both flags.
// - after power-on irq_enable is cleared until software sets it; irq_mask is cleared only by rst_n.
// - after power-on the watchdog counter is cleared and counts at once.
// - after power-on the timer/event counter is stopped.
// - after power-on the timer prescaler is cleared.
// - after power-on every port pin is an input.
// - after power-on the stack pointer points at the top of the stack.
// - any reset forces the program counter to zero.
// - a watchdog reset in sleep resets only program counter, stack pointer and sleep mode and sets both flags.
`timescale 1ns/1ps
module rsi_top
  import rsi_pkg::*;
#(
  parameter int WDT_WIDTH = 16,
  parameter logic [15:0] WDT_LIMIT = 16'hffff
) (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // reset sources, synchronous one-cycle pulses
  input wire logic power_on_reset,
  input wire logic external_reset_pin,
  input wire logic low_voltage_reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // reset-state outputs to the core
  output logic cpu_run,
  output logic [7:0] program_counter,
  output logic [3:0] stack_pointer,
  output logic irq_enable,
  output logic timer_run,
  output logic [7:0] prescaler,
  output logic [7:0] port_dir,
  output logic watchdog_timeout_flag,
  output logic powerdown_flag,
  // interrupt
  output logic irq
);
  rsi_state_e state;
  rsi_flags_s flags;
  logic [EV_N-1:0] irq_status;
  logic [EV_N-1:0] irq_mask;
  logic [EV_N-1:0] ev_vec;
  logic sleep_mode;
  logic [WDT_WIDTH-1:0] wdt_count;
  logic wdt_timeout;
  logic ev_por;
  logic ev_wdt;
  logic any_reset;
  logic sleep_wdt;
  logic full_reset;
  logic wr_ok;
  logic rd_ok;
  logic addr_ok;

  // power-on is also the bus reset, so a held rst_n acts as power-on
  assign ev_por = power_on_reset || !rst_n;
  assign ev_wdt = wdt_timeout && !ev_por;
  assign any_reset = ev_por || external_reset_pin || low_voltage_reset || ev_wdt;
  assign sleep_wdt = ev_wdt && sleep_mode && !external_reset_pin && !low_voltage_reset;
  // every kind but sleep watchdog reloads the full default set
  assign full_reset = any_reset && !sleep_wdt;
  assign ev_vec = {sleep_wdt, ev_wdt && !sleep_mode, low_voltage_reset, external_reset_pin, ev_por};

  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == REG_CAUSE) || (a == REG_CTRL) || (a == REG_IRQ_STATUS) ||
      (a == REG_IRQ_MASK) || (a == REG_STATE) || (a == REG_COUNT);
  endfunction

  assign addr_ok = addr_hit(paddr);
  assign wr_ok = psel && penable && pwrite && ce;
  assign rd_ok = psel && penable && !pwrite && ce;
  // zero wait states, error on unmapped address
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  // cause flags; pin and lvr pass no event so flags hold
  rsi_flag_unit u_flags (
    .clk_sys(clk_sys),
    .ce(ce),
    .ev_por(ev_por),
    .ev_wdt(ev_wdt),
    .in_sleep(sleep_mode),
    .flags(flags)
  );
  assign watchdog_timeout_flag = flags.watchdog_timeout_flag;
  assign powerdown_flag = flags.powerdown_flag;

  // watchdog restarts on every reset; software kicks by writing count
  rsi_wdt #(.WIDTH(WDT_WIDTH)) u_wdt (
    .clk_sys(clk_sys),
    .ce(ce),
    .clear(any_reset),
    .kick(wr_ok && paddr == REG_COUNT),
    .limit(WDT_LIMIT[WDT_WIDTH-1:0]),
    .count(wdt_count),
    .timeout(wdt_timeout)
  );

  // sequencer: apply defaults, then one cycle to settle flags before run
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state <= ST_APPLY;
    end else if (ce) begin
      case (state)
        ST_RUN: begin
          if (any_reset) begin
            state <= ST_APPLY;
          end
        end
        ST_APPLY: begin
          state <= any_reset ? ST_APPLY : ST_RELEASE;
        end
        ST_RELEASE: begin
          state <= any_reset ? ST_APPLY : ST_RUN;
        end
        default: begin
          state <= ST_APPLY;
        end
      endcase
    end
  end
  // core held until flags are already latched
  assign cpu_run = (state == ST_RUN);

  // program counter clears and stack pointer reloads to the top on every reset
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      program_counter <= PC_RESET;
      stack_pointer <= SP_TOP;
    end else if (ce) begin
      if (any_reset) begin
        program_counter <= PC_RESET;
        stack_pointer <= SP_TOP;
      end else if (cpu_run) begin
        program_counter <= program_counter + 8'h01;
      end
    end
  end

  // defaults reload, except on sleep watchdog where only sleep mode clears and the rest is kept
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      irq_enable <= 1'b0;
      timer_run <= 1'b0;
      prescaler <= PRESCALE_RESET;
      port_dir <= PORT_DIR_RESET;
      sleep_mode <= 1'b0;
    end else if (ce) begin
      if (full_reset) begin
        irq_enable <= 1'b0;
        timer_run <= 1'b0;
        prescaler <= PRESCALE_RESET;
        port_dir <= PORT_DIR_RESET;
        sleep_mode <= 1'b0;
      end else if (sleep_wdt) begin
        sleep_mode <= 1'b0;
      end else begin
        if (wr_ok && paddr == REG_CTRL) begin
          sleep_mode <= pwdata[CTRL_SLEEP_BIT];
          irq_enable <= pwdata[CTRL_IRQEN_BIT];
          timer_run <= pwdata[CTRL_TIMER_BIT];
        end
        if (wr_ok && paddr == REG_STATE) begin
          port_dir <= pwdata[7:0];
        end
        if (timer_run) begin
          prescaler <= prescaler + 8'h01;
        end
      end
    end
  end

  // sticky event bits, set wins over write-one-to-clear
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      irq_status <= '0;
      irq_mask <= '0;
    end else if (ce) begin
      if (wr_ok && paddr == REG_IRQ_MASK) begin
        irq_mask <= pwdata[EV_N-1:0];
      end
      if (wr_ok && paddr == REG_IRQ_STATUS) begin
        irq_status <= (irq_status & ~pwdata[EV_N-1:0]) | ev_vec;
      end else begin
        irq_status <= irq_status | ev_vec;
      end
    end
  end
  assign irq = |(irq_status & irq_mask);

  // read data registered during the setup cycle for the access phase
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      prdata <= '0;
    end else if (ce) begin
      if (psel && !penable && !pwrite) begin
        case (paddr)
          REG_CAUSE: prdata <= {30'h0, flags.powerdown_flag, flags.watchdog_timeout_flag};
          REG_CTRL: prdata <= {28'h0, timer_run, irq_enable, cpu_run, sleep_mode};
          REG_IRQ_STATUS: prdata <= {{(32-EV_N){1'b0}}, irq_status};
          REG_IRQ_MASK: prdata <= {{(32-EV_N){1'b0}}, irq_mask};
          REG_STATE: prdata <= {8'h0, prescaler, 4'h0, stack_pointer, port_dir};
          REG_COUNT: prdata <= 32'(wdt_count);
          default: prdata <= '0;
        endcase
      end else if (!rd_ok) begin
        prdata <= prdata;
      end
    end
  end
endmodule

//--- core/rsi_wdt.sv
// watchdog counter with timeout pulse
`timescale 1ns/1ps
module rsi_wdt
  import rsi_pkg::*;
#(
  parameter int WIDTH = 16
) (
  // clock and control
  input wire logic clk_sys,
  input wire logic ce,
  input wire logic clear,
  input wire logic kick,
  input wire logic [WIDTH-1:0] limit,
  // status
  output logic [WIDTH-1:0] count,
  output logic timeout
);
  // cleared on reset, counts from the next cycle on
  always_ff @(posedge clk_sys) begin
    if (ce) begin
      timeout <= 1'b0;
      if (clear || kick) begin
        count <= WDT_RESET[WIDTH-1:0];
      end else if (count >= limit) begin
        count <= WDT_RESET[WIDTH-1:0];
        timeout <= 1'b1;
      end else begin
        count <= count + 1'b1;
      end
    end
  end
endmodule

//--- verif/rsi_top_assertions.sv
// concurrent checks on the reset-state initialiser ports
`timescale 1ns/1ps
module rsi_top_assertions
  import rsi_pkg::*;
(
  // clock, reset, reset sources, apb
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic power_on_reset,
  input wire logic external_reset_pin,
  input wire logic low_voltage_reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  // reset-state outputs
  input wire logic cpu_run,
  input wire logic [7:0] program_counter,
  input wire logic [3:0] stack_pointer,
  input wire logic irq_enable,
  input wire logic timer_run,
  input wire logic [7:0] prescaler,
  input wire logic [7:0] port_dir,
  input wire logic watchdog_timeout_flag,
  input wire logic powerdown_flag
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // any pulsed reset input: power-on, pin or low-voltage, watchdog excluded
  wire logic any_rst = power_on_reset | external_reset_pin | low_voltage_reset;
  a_por_flags_clear: assert property (power_on_reset |=> !watchdog_timeout_flag && !powerdown_flag)
    else $error("flags not cleared by power-on reset");
  a_pin_flags_keep: assert property ((external_reset_pin || low_voltage_reset) && !power_on_reset
    |=> $stable({watchdog_timeout_flag, powerdown_flag})) else $error("flags changed by pin reset");
  a_reset_pc_zero: assert property (any_rst |=> (program_counter == 8'h00 && stack_pointer == 4'hf) [*2])
    else $error("pc or sp not reloaded by reset");
  a_por_defaults: assert property (power_on_reset |=> !irq_enable && !timer_run && prescaler == 8'h00
    && port_dir == 8'hff) else $error("power-on defaults wrong");
  a_cause_first: assert property (any_rst |=> !cpu_run [*2] ##1 cpu_run)
    else $error("execution resumed at the wrong cycle");
  a_pd_with_to: assert property ($rose(powerdown_flag) |-> watchdog_timeout_flag && !cpu_run)
    else $error("powerdown flag set without timeout");
  a_sleep_keeps: assert property ($rose(powerdown_flag) |-> $stable(port_dir) && $stable(irq_enable))
    else $error("sleep timeout lost state");
  a_irq_en_write: assert property ($rose(irq_enable) |-> $past(psel && penable && pwrite && paddr == REG_CTRL))
    else $error("interrupts enabled without a write");
  a_to_on_wdt: assert property ($rose(watchdog_timeout_flag) |-> !cpu_run && program_counter == 8'h00)
    else $error("timeout flag set outside a reset");
endmodule

//--- verif/rsi_top_bench.sv
// self-checking bench for the reset-state initialiser
`timescale 1ns/1ps
module rsi_top_bench
  import rsi_pkg::*;
;
  logic clk_sys, rst_n, ce, power_on_reset, external_reset_pin, low_voltage_reset;
  logic psel, penable, pwrite, pready, pslverr, cpu_run, irq_enable, timer_run, err;
  logic watchdog_timeout_flag, powerdown_flag, irq;
  logic [7:0] paddr, program_counter, prescaler, port_dir, p;
  logic [31:0] pwdata, prdata, rd, c0;
  logic [3:0] stack_pointer;
  logic [1:0] ef;
  int n_fail = 0, samples_checked = 0, cyc = 0, t;
  // short watchdog limit keeps timeout scenarios brief
  rsi_top #(.WDT_LIMIT(16'h0100)) uut (.*);
  initial begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end
  // cycle ceiling so a hang still ends in a verdict
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // expected {powerdown, timeout}: 0 por, 1 pin or lvr, 2 wdt, 3 wdt in sleep
  function automatic logic [1:0] exp_fl(input int k, input logic [1:0] o);
    case (k)
      0: return 2'b00;
      1: return o;
      2: return {o[1], 1'b1};
      default: return 2'b11;
    endcase
  endfunction
  // one apb transfer, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    @(posedge clk_sys);
    // wait states end only when pready is seen; the cycle ceiling catches a hang
    while (pready !== 1'b1) begin
      @(posedge clk_sys);
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    // one idle edge so a following call never drives psel twice in a time step
    @(posedge clk_sys);
  endtask
  task automatic chk_def();
    chk("sp", 4'hf, stack_pointer);
    chk("ports", 8'hff, port_dir);
    chk("irq_en", 0, irq_enable);
    chk("timer", 0, timer_run);
    chk("presc", 0, prescaler);
  endtask
  // pc still zero two edges after a reset, core not yet running
  task automatic pc_zero();
    chk("pc", 0, program_counter);
    chk("run", 0, cpu_run);
  endtask
  task automatic pulse(input int k);
    ef = {powerdown_flag, watchdog_timeout_flag};
    power_on_reset <= (k == 0);
    external_reset_pin <= (k == 1);
    low_voltage_reset <= (k == 2);
    @(posedge clk_sys);
    {power_on_reset, external_reset_pin, low_voltage_reset} <= 3'b000;
    @(posedge clk_sys);
    pc_zero();
    chk("flags", exp_fl(k == 0 ? 0 : 1, ef), {powerdown_flag, watchdog_timeout_flag});
    repeat (3) @(posedge clk_sys);
  endtask
  // wait for a watchdog reset; k 2 normal, 3 in sleep
  task automatic wdt_wait(input int k);
    ef = {powerdown_flag, watchdog_timeout_flag};
    t = 0;
    while ((k == 2 ? watchdog_timeout_flag : powerdown_flag) !== 1'b1 && t < 600) begin
      t++;
      @(posedge clk_sys);
    end
    pc_zero();
    chk("wdt flags", exp_fl(k, ef), {powerdown_flag, watchdog_timeout_flag});
    chk("sp", 4'hf, stack_pointer);
    repeat (4) @(posedge clk_sys);
  endtask
  initial begin
    {ce, rst_n, power_on_reset, external_reset_pin, low_voltage_reset} = 5'b10000;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    void'($urandom(76574));
    repeat (20) @(posedge clk_sys);
    rst_n <= 1;
    repeat (4) @(posedge clk_sys);
    chk_def();
    chk("flags", 0, {powerdown_flag, watchdog_timeout_flag});
    // clock enable low freezes the running program counter
    ce <= 0;
    repeat (3) @(posedge clk_sys);
    c0 = {24'h0, program_counter};
    repeat (2) @(posedge clk_sys);
    chk("pc frozen", c0, program_counter);
    ce <= 1;
    apb(0, REG_COUNT, 0);
    c0 = rd;
    apb(0, REG_COUNT, 0);
    chk("wdt counts", 1, rd > c0);
    apb(1, 8'h18, $urandom);
    chk("slverr", 1, err);
    apb(0, 8'h18, 0);
    chk("unmapped", 0, rd);
    // pin and low-voltage resets after random configuration
    for (int k = 1; k < 3; k++) begin
      apb(1, REG_COUNT, 0);
      apb(1, REG_STATE, {24'h0, 8'($urandom)});
      apb(1, REG_CTRL, {28'h0, 2'($urandom), 2'b00});
      pulse(k);
      chk_def();
    end
    apb(1, REG_COUNT, 0);
    wdt_wait(2);
    chk_def();
    // sleep timeout keeps configuration
    apb(1, REG_COUNT, 0);
    p = 8'($urandom);
    apb(1, REG_STATE, {24'h0, p});
    apb(1, REG_CTRL, 32'h5);
    wdt_wait(3);
    chk("ports kept", p, port_dir);
    chk("irq_en kept", 1, irq_enable);
    // pin and low-voltage resets must keep flags that are now both set
    pulse(1);
    chk_def();
    pulse(2);
    chk_def();
    pulse(0);
    chk_def();
    apb(0, REG_CAUSE, 0);
    chk("cause", 0, rd[1:0]);
    // interrupt status, mask and clear
    apb(0, REG_IRQ_STATUS, 0);
    chk("status", 32'h1f, rd);
    apb(1, REG_IRQ_MASK, 0);
    @(posedge clk_sys);
    chk("irq masked", 0, irq);
    apb(1, REG_IRQ_MASK, 32'h1f);
    @(posedge clk_sys);
    chk("irq", 1, irq);
    apb(1, REG_IRQ_STATUS, 32'h1f);
    @(posedge clk_sys);
    chk("irq clr", 0, irq);
    apb(0, REG_IRQ_STATUS, 0);
    chk("status clr", 0, rd);
    give_verdict();
  end
endmodule
bind rsi_top rsi_top_assertions chk_i (.*);
